// *** rtl/ssn_notice_tx.sv ***
`timescale 1ns/10ps
// How it works
// - no notices when running at Gen 1
// - speed is mantissa times 1000 power exponent
// - sublink speed is lane speed times lanes+1
// - SET_ADDRESS status ACK carries TP Follows
// - receive notice is next packet after ACK
// - receive notice carries TP Follows
// - transmit notice directly follows receive notice
// - symmetric single-lane link only
// - dword 1 subtype, notice type, reserved zero
// - 2-bit exponent at dword 2 bit 4
// - exponent codes b, Kb, Mb, Gb per second
// - 2-bit sublink type at dword 2 bit 6
// - direction bit 0 in receive notice
// - pair shares one speed snapshot
// - direction bit 1 in transmit notice
// - lane count field zero at bit 10
// - protocol field 01b at bit 14
// - 16-bit mantissa at dword 2 bit 16
module ssn_notice_tx
    import ssn_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        addr_ack_req,
    input  wire logic        addr_ack_sent,
    output logic             ack_tpf,
    output logic             tp_hold,
    output logic             ntf_valid,
    input  wire logic        ntf_ready,
    output logic      [31:0] ntf_dw1,
    output logic      [31:0] ntf_dw2
);

    function automatic logic ssn_hit(input logic [11:0] a, input logic [11:0] off);
        return a == off;
    endfunction

    ssn_state_t  state_reg;
    ssn_state_t  state_next;
    logic [1:0]  ctrl_reg;
    logic [1:0]  ctrl_next;
    logic [15:0] lsm_reg;
    logic [15:0] lsm_next;
    logic [1:0]  lse_reg;
    logic [1:0]  lse_next;
    logic        sent_reg;
    logic        sent_next;
    logic [7:0]  cnt_reg;
    logic [7:0]  cnt_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic        wr_en;
    logic        rd_setup;
    logic        mapped;
    logic        arm;
    logic        load;
    logic        load_dir;
    logic [15:0] snap_lsm;
    logic [1:0]  snap_lse;

    // register bus: zero wait states, unmapped access answers with an error
    always_comb begin
        mapped = ssn_hit(paddr, SSN_OFF_CTRL) || ssn_hit(paddr, SSN_OFF_SPEED)
              || ssn_hit(paddr, SSN_OFF_STATUS) || ssn_hit(paddr, SSN_OFF_DW1)
              || ssn_hit(paddr, SSN_OFF_DW2);
        wr_en    = psel && penable && pwrite;
        rd_setup = psel && !penable && !pwrite;
        pready   = 1'b1;
        pslverr  = psel && penable && !mapped;
        prdata   = rdata_reg;
    end

    always_comb begin
        ctrl_next  = ctrl_reg;
        lsm_next   = lsm_reg;
        lse_next   = lse_reg;
        rdata_next = rdata_reg;
        if (wr_en && ssn_hit(paddr, SSN_OFF_CTRL) && pstrb[0]) begin
            ctrl_next = pwdata[1:0];
        end
        if (wr_en && ssn_hit(paddr, SSN_OFF_SPEED)) begin
            if (pstrb[0]) begin
                lsm_next[7:0] = pwdata[7:0];
            end
            if (pstrb[1]) begin
                lsm_next[15:8] = pwdata[15:8];
            end
            if (pstrb[2]) begin
                lse_next = pwdata[SSN_SPD_LSE_LSB +: 2];
            end
        end
        // read data is prepared in the setup phase so it comes from a flop
        if (rd_setup) begin
            rdata_next = '0;
            if (ssn_hit(paddr, SSN_OFF_CTRL)) begin
                rdata_next[1:0] = ctrl_reg;
            end else if (ssn_hit(paddr, SSN_OFF_SPEED)) begin
                rdata_next[15:0] = lsm_reg;
                rdata_next[SSN_SPD_LSE_LSB +: 2] = lse_reg;
            end else if (ssn_hit(paddr, SSN_OFF_STATUS)) begin
                rdata_next[4:0] = state_reg;
                rdata_next[SSN_ST_SENT_BIT] = sent_reg;
                rdata_next[SSN_ST_CNT_LSB +: 8] = cnt_reg;
            end else if (ssn_hit(paddr, SSN_OFF_DW1)) begin
                rdata_next = ntf_dw1;
            end else if (ssn_hit(paddr, SSN_OFF_DW2)) begin
                rdata_next = ntf_dw2;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg  <= SSN_CTRL_RST;
            lsm_reg   <= SSN_LSM_RST;
            lse_reg   <= SSN_LSE_RST;
            rdata_reg <= '0;
        end else begin
            ctrl_reg  <= ctrl_next;
            lsm_reg   <= lsm_next;
            lse_reg   <= lse_next;
            rdata_reg <= rdata_next;
        end
    end

    // sequence state machine
    always_comb begin
        state_next = state_reg;
        sent_next  = sent_reg;
        cnt_next   = cnt_reg;
        arm        = 1'b0;
        load       = 1'b0;
        load_dir   = SSN_DIR_RX;
        case (state_reg)
            SSN_IDLE, SSN_DONE: begin
                // restart only on a new address
                if (addr_ack_req && ctrl_reg[SSN_CTRL_EN_BIT]
                    && !ctrl_reg[SSN_CTRL_GEN1_BIT]) begin
                    arm        = 1'b1;
                    sent_next  = 1'b0;
                    state_next = SSN_ARMED;
                end
            end
            SSN_ARMED: begin
                if (addr_ack_sent) begin
                    load       = 1'b1;
                    load_dir   = SSN_DIR_RX;
                    state_next = SSN_RX;
                end
            end
            SSN_RX: begin
                if (ntf_ready) begin
                    load       = 1'b1;
                    load_dir   = SSN_DIR_TX;
                    state_next = SSN_TX;
                end
            end
            SSN_TX: begin
                if (ntf_ready) begin
                    sent_next  = 1'b1;
                    cnt_next   = cnt_reg + 8'h01;
                    state_next = SSN_DONE;
                end
            end
            default: begin
                state_next = SSN_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= SSN_IDLE;
            sent_reg  <= 1'b0;
            cnt_reg   <= 8'h00;
        end else begin
            state_reg <= state_next;
            sent_reg  <= sent_next;
            cnt_reg   <= cnt_next;
        end
    end

    // TP Follows flag for the ACK
    assign ack_tpf = (state_reg == SSN_ARMED);
    // no other packet may slip in while the sequence runs
    assign tp_hold = (state_reg == SSN_ARMED) || (state_reg == SSN_RX) || (state_reg == SSN_TX);
    assign ntf_valid = (state_reg == SSN_RX) || (state_reg == SSN_TX);

    ssn_speed_snap u_snap (
        .pclk    (pclk),
        .presetn (presetn),
        .capture (arm),
        .lsm_in  (lsm_reg),
        .lse_in  (lse_reg),
        .lsm_reg (snap_lsm),
        .lse_reg (snap_lse)
    );

    ssn_tp_build u_build (
        .pclk    (pclk),
        .presetn (presetn),
        .load    (load),
        .dir     (load_dir),
        .lsm     (snap_lsm),
        .lse     (snap_lse),
        .dw1_reg (ntf_dw1),
        .dw2_reg (ntf_dw2)
    );

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_ack_out;
        state_reg == SSN_ARMED && addr_ack_sent;
    endsequence

    sequence s_rx_out;
        state_reg == SSN_RX && ntf_ready;
    endsequence

    sequence s_tx_out;
        state_reg == SSN_TX && ntf_ready;
    endsequence

    // flag only while armed and held
    a_ack_tpf_hold: assert property (ack_tpf |-> tp_hold && !ntf_valid)
        else $error("ack flag without hold");

    a_rx_after_ack: assert property (s_ack_out |=> ntf_valid && ntf_dw2[SSN_DIR_BIT] == SSN_DIR_RX)
        else $error("receive notice not next after ACK");

    a_rx_tpf_set: assert property (s_ack_out |=> ntf_dw1[SSN_TPF_BIT] && !ntf_dw2[SSN_DIR_BIT])
        else $error("receive notice lacks follow flag");

    a_tx_after_rx: assert property (s_rx_out |=> ntf_valid && ntf_dw2[SSN_DIR_BIT] && !ntf_dw1[SSN_TPF_BIT])
        else $error("transmit notice not next after receive");

    a_pair_speed: assert property (s_rx_out |=> ntf_dw2[31:16] == $past(ntf_dw2[31:16])
                                   && ntf_dw2[5:4] == $past(ntf_dw2[5:4]))
        else $error("pair speed differs");

    a_sym_lane: assert property (ntf_valid |-> !ntf_dw2[SSN_ASYM_BIT]
                                 && ntf_dw2[SSN_LANES_LSB +: 4] == SSN_LANES_ONE
                                 && ntf_dw2[SSN_LP_LSB +: 2] == SSN_LP_CODE)
        else $error("asymmetric, multi-lane or bad protocol");

    a_dw1_fields: assert property (ntf_valid |-> ntf_dw1[3:0] == SSN_SUBTYPE_DEVNTF
                                   && ntf_dw1[7:4] == SSN_NTYPE_SPEED && ntf_dw1[30:8] == '0)
        else $error("dword 1 fields wrong");

    a_speed_src: assert property (ntf_valid |-> ntf_dw2[SSN_LSM_LSB +: 16] == snap_lsm
                                  && ntf_dw2[SSN_LSE_LSB +: 2] == snap_lse)
        else $error("speed fields not from snapshot");

    a_gen1_quiet: assert property (ctrl_reg[SSN_CTRL_GEN1_BIT] && (state_reg == SSN_IDLE || state_reg == SSN_DONE)
                                   |=> state_reg != SSN_ARMED)
        else $error("armed at Gen 1");

    a_once_pair: assert property (state_reg == SSN_DONE && !addr_ack_req |=> state_reg == SSN_DONE)
        else $error("pair restarted without new address");

    a_pair_close: assert property (s_tx_out |=> !ntf_valid && !tp_hold && !ack_tpf)
        else $error("sequence still open after transmit notice");

    a_ntf_held: assert property (ntf_valid && !ntf_ready |=> ntf_valid && $stable(ntf_dw1) && $stable(ntf_dw2))
        else $error("notice changed before taken");

    a_pair_count: assert property (s_tx_out |=> sent_reg && cnt_reg == $past(cnt_reg) + 8'h01)
        else $error("pair count not advanced");

    a_off_quiet: assert property (!ctrl_reg[SSN_CTRL_EN_BIT] && !tp_hold |=> !tp_hold)
        else $error("sequence started while disabled");

endmodule // ssn_notice_tx

// *** rtl/ssn_pkg.sv ***
package ssn_pkg;

    // register byte offsets
    localparam logic [11:0] SSN_OFF_CTRL   = 12'h000;
    localparam logic [11:0] SSN_OFF_SPEED  = 12'h004;
    localparam logic [11:0] SSN_OFF_STATUS = 12'h008;
    localparam logic [11:0] SSN_OFF_DW1    = 12'h00C;
    localparam logic [11:0] SSN_OFF_DW2    = 12'h010;

    // control register bits
    localparam int SSN_CTRL_EN_BIT   = 0;
    localparam int SSN_CTRL_GEN1_BIT = 1;
    localparam logic [1:0] SSN_CTRL_RST = 2'h0;

    // speed register layout and reset value (10 Gb/s)
    localparam int SSN_SPD_LSE_LSB = 16;
    localparam logic [15:0] SSN_LSM_RST = 16'h000A;
    localparam logic [1:0]  SSN_LSE_RST = 2'h3;

    // status register layout
    localparam int SSN_ST_SENT_BIT = 8;
    localparam int SSN_ST_CNT_LSB  = 16;

    // exponent codes: unit of the mantissa
    localparam logic [1:0] SSN_LSE_BPS  = 2'h0;
    localparam logic [1:0] SSN_LSE_KBPS = 2'h1;
    localparam logic [1:0] SSN_LSE_MBPS = 2'h2;
    localparam logic [1:0] SSN_LSE_GBPS = 2'h3;

    // packet dword 1 fields
    localparam int SSN_SUBTYPE_LSB = 0;
    localparam int SSN_NTYPE_LSB   = 4;
    localparam int SSN_TPF_BIT     = 31;
    localparam logic [3:0] SSN_SUBTYPE_DEVNTF = 4'h4;
    localparam logic [3:0] SSN_NTYPE_SPEED    = 4'h6;

    // packet dword 2 fields
    localparam int SSN_LSE_LSB   = 4;
    localparam int SSN_ASYM_BIT  = 6;
    localparam int SSN_DIR_BIT   = 7;
    localparam int SSN_LANES_LSB = 10;
    localparam int SSN_LP_LSB    = 14;
    localparam int SSN_LSM_LSB   = 16;
    localparam logic [1:0] SSN_LP_CODE   = 2'h1;
    localparam logic [3:0] SSN_LANES_ONE = 4'h0;
    localparam logic       SSN_DIR_RX    = 1'b0;
    localparam logic       SSN_DIR_TX    = 1'b1;

    typedef enum logic [4:0] {
        SSN_IDLE  = 5'h01,
        SSN_ARMED = 5'h02,
        SSN_RX    = 5'h04,
        SSN_TX    = 5'h08,
        SSN_DONE  = 5'h10
    } ssn_state_t;

endpackage

// *** rtl/ssn_speed_snap.sv ***
`timescale 1ns/10ps
module ssn_speed_snap
    import ssn_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        capture,
    input  wire logic [15:0] lsm_in,
    input  wire logic [1:0]  lse_in,
    output logic      [15:0] lsm_reg,
    output logic      [1:0]  lse_reg
);
    logic [15:0] lsm_next;
    logic [1:0]  lse_next;

    // frozen for the whole pair even if software rewrites the speed
    always_comb begin
        lsm_next = lsm_reg;
        lse_next = lse_reg;
        if (capture) begin
            lsm_next = lsm_in;
            lse_next = lse_in;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lsm_reg <= SSN_LSM_RST;
            lse_reg <= SSN_LSE_RST;
        end else begin
            lsm_reg <= lsm_next;
            lse_reg <= lse_next;
        end
    end
endmodule // ssn_speed_snap

// *** rtl/ssn_tp_build.sv ***
`timescale 1ns/10ps
module ssn_tp_build
    import ssn_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        load,
    input  wire logic        dir,
    input  wire logic [15:0] lsm,
    input  wire logic [1:0]  lse,
    output logic      [31:0] dw1_reg,
    output logic      [31:0] dw2_reg
);
    logic [31:0] dw1_next;
    logic [31:0] dw2_next;

    always_comb begin
        dw1_next = dw1_reg;
        dw2_next = dw2_reg;
        if (load) begin
            dw1_next = '0;
            dw1_next[SSN_SUBTYPE_LSB +: 4] = SSN_SUBTYPE_DEVNTF;
            dw1_next[SSN_NTYPE_LSB +: 4]   = SSN_NTYPE_SPEED;
            dw1_next[SSN_TPF_BIT]          = (dir == SSN_DIR_RX);
            dw2_next = '0;
            dw2_next[SSN_LSE_LSB +: 2]     = lse;
            dw2_next[SSN_ASYM_BIT]         = 1'b0;
            dw2_next[SSN_DIR_BIT]          = dir;
            dw2_next[SSN_LANES_LSB +: 4]   = SSN_LANES_ONE;
            dw2_next[SSN_LP_LSB +: 2]      = SSN_LP_CODE;
            dw2_next[SSN_LSM_LSB +: 16]    = lsm;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dw1_reg <= '0;
            dw2_reg <= '0;
        end else begin
            dw1_reg <= dw1_next;
            dw2_reg <= dw2_next;
        end
    end
endmodule // ssn_tp_build

// *** verif/ssn_link_model.sv ***
`timescale 1ns/10ps
// far-side link layer: takes each notice after a chosen number of stall cycles
module ssn_link_model
    import ssn_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [2:0]  delay,
    input  wire logic        ntf_valid,
    input  wire logic [31:0] ntf_dw1,
    input  wire logic [31:0] ntf_dw2,
    output logic             ntf_ready,
    output logic      [7:0]  n_taken,
    output logic      [31:0] cap_dw1 [2],
    output logic      [31:0] cap_dw2 [2]
);
    logic [2:0] wait_cnt;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ntf_ready <= 1'b0;
            n_taken   <= 8'h00;
            wait_cnt  <= 3'h0;
        end else if (ntf_valid && ntf_ready) begin
            cap_dw1[n_taken[0]] <= ntf_dw1;
            cap_dw2[n_taken[0]] <= ntf_dw2;
            n_taken   <= n_taken + 8'h01;
            ntf_ready <= 1'b0;
            wait_cnt  <= 3'h0;
        end else if (ntf_valid) begin
            if (wait_cnt >= delay) begin
                ntf_ready <= 1'b1;
            end else begin
                wait_cnt <= wait_cnt + 3'h1;
            end
        end
    end
endmodule // ssn_link_model

// *** verif/sublink_speed_notice_tx_tb.sv ***
`timescale 1ns/10ps
module sublink_speed_notice_tx_tb
    import ssn_pkg::*;
;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, ntf_dw1, ntf_dw2, q, cap_dw1 [2], cap_dw2 [2];
    logic [3:0]  pstrb = 4'hF;
    logic        pready, pslverr, e, ack_tpf, tp_hold, ntf_valid, ntf_ready;
    logic        addr_ack_req = 1'b0, addr_ack_sent = 1'b0;
    logic [2:0]  delay = 3'h0;
    logic [7:0]  n_taken;
    int          n_mismatch = 0, check_count = 0;

    ssn_notice_tx i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .addr_ack_req(addr_ack_req), .addr_ack_sent(addr_ack_sent), .ack_tpf(ack_tpf), .tp_hold(tp_hold),
        .ntf_valid(ntf_valid), .ntf_ready(ntf_ready), .ntf_dw1(ntf_dw1), .ntf_dw2(ntf_dw2));
    ssn_link_model i_link (.pclk(pclk), .presetn(presetn), .delay(delay), .ntf_valid(ntf_valid),
        .ntf_dw1(ntf_dw1), .ntf_dw2(ntf_dw2), .ntf_ready(ntf_ready), .n_taken(n_taken),
        .cap_dw1(cap_dw1), .cap_dw2(cap_dw2));

    initial begin
        forever #2 pclk = ~pclk;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", name, exp, got);
            n_mismatch++;
        end
    endtask

    // master holds the request until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    // one-cycle pulse on addr_ack_sent (sent=1) or addr_ack_req (sent=0)
    task automatic pulse(input logic sent);
        @(posedge pclk);
        if (sent) begin
            addr_ack_sent <= 1'b1;
        end else begin
            addr_ack_req <= 1'b1;
        end
        @(posedge pclk);
        addr_ack_sent <= 1'b0;
        addr_ack_req  <= 1'b0;
        #1;
    endtask

    function automatic logic [31:0] dw2_of(logic [15:0] m, logic [1:0] x, logic dir);
        return {m, SSN_LP_CODE, SSN_LANES_ONE, 2'h0, dir, 1'b0, x, 4'h0};
    endfunction

    task automatic t_regs();
        apb(0, SSN_OFF_CTRL, 0);   chk("ctrl rst", 32'h0, q);
        apb(0, SSN_OFF_SPEED, 0);  chk("speed rst", {14'h0, SSN_LSE_RST, SSN_LSM_RST}, q);
        // byte enables: exponent byte masked off
        pstrb <= 4'h3;
        apb(1, SSN_OFF_SPEED, 32'h0001_5555);
        pstrb <= 4'hF;
        apb(0, SSN_OFF_SPEED, 0);
        chk("speed strobe", {14'h0, SSN_LSE_RST, 16'h5555}, q);
        apb(1, SSN_OFF_STATUS, 32'hFFFF_FFFF);
        apb(0, SSN_OFF_STATUS, 0); chk("status ro", 32'h1, q);
        apb(0, 12'h0FC, 0);        chk("unmapped err", 32'h1, {31'h0, e});
        $display("test regs done");
    endtask

    task automatic t_pair(input logic [15:0] m, input logic [1:0] x, input logic [2:0] dl, input logic [7:0] n);
        logic [31:0] rx1;
        rx1 = {1'b1, 23'h0, SSN_NTYPE_SPEED, SSN_SUBTYPE_DEVNTF};
        delay <= dl;
        apb(1, SSN_OFF_SPEED, {14'h0, x, m});
        apb(1, SSN_OFF_CTRL, 32'h1);
        pulse(1'b0);
        chk("ack_tpf", 1, ack_tpf);
        chk("tp_hold", 1, tp_hold);
        apb(1, SSN_OFF_SPEED, {14'h0, ~x, ~m});
        pulse(1'b1);
        chk("ack_tpf clr", 0, ack_tpf);
        chk("valid", 1, ntf_valid);
        repeat (30) if (n_taken[0] !== 1'b0 || ntf_valid === 1'b1) @(posedge pclk);
        #1;
        chk("hold end", 0, tp_hold);
        chk("rx dw1", rx1, cap_dw1[0]);
        chk("rx dw2", dw2_of(m, x, SSN_DIR_RX), cap_dw2[0]);
        chk("tx dw1", {1'b0, rx1[30:0]}, cap_dw1[1]);
        chk("tx dw2", dw2_of(m, x, SSN_DIR_TX), cap_dw2[1]);
        apb(0, SSN_OFF_STATUS, 0);
        chk("status", {8'h0, n, 7'h0, 1'b1, 8'h10}, q);
        apb(0, SSN_OFF_DW2, 0);
        chk("dw2 reg", dw2_of(m, x, SSN_DIR_TX), q);
        pulse(1'b1);
        repeat (3) @(posedge pclk);
        #1;
        chk("no resend", 0, ntf_valid);
        $display("test pair %0d done", n);
    endtask

    task automatic t_gen1(input logic [31:0] c);
        apb(1, SSN_OFF_CTRL, c);
        pulse(1'b0);
        chk("gen1 ack", 0, ack_tpf);
        pulse(1'b1);
        chk("gen1 valid", 0, ntf_valid);
        $display("test blocked ctrl %0h done", c);
    endtask

    // reset dropped while armed: sequence abandoned, registers back to reset values
    task automatic t_reset();
        apb(1, SSN_OFF_CTRL, 32'h1);
        pulse(1'b0);
        chk("armed before reset", 1, ack_tpf);
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        #1;
        chk("reset ack_tpf", 0, ack_tpf);
        chk("reset tp_hold", 0, tp_hold);
        chk("reset valid", 0, ntf_valid);
        @(posedge pclk);
        presetn <= 1'b1;
        pulse(1'b1);
        chk("sent ignored after reset", 0, ntf_valid);
        apb(0, SSN_OFF_STATUS, 0);
        chk("reset status", 32'h1, q);
        apb(0, SSN_OFF_CTRL, 0);
        chk("reset ctrl", 32'h0, q);
        apb(0, SSN_OFF_SPEED, 0);
        chk("reset speed", {14'h0, SSN_LSE_RST, SSN_LSM_RST}, q);
        $display("test reset done");
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        test_done();
    end

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        for (int i = 0; i < 4; i++) begin
            t_pair(16'h1234 + 16'(i) * 16'h1111, 2'(i), 3'(i), 8'(i + 1));
        end
        t_gen1(32'h3);
        t_gen1(32'h0);
        t_reset();
        test_done();
    end
endmodule // sublink_speed_notice_tx_tb
